// File: ttu_pkg.sv
// constants and state type of the timekeeping timer unit
package ttu_pkg;

  // ==========================================================
  // widths
  localparam int DIV_W = 14;
  localparam int NIB_W = 4;
  localparam int CNT_W = 8;
  localparam int EVF_W = 8;

  // ==========================================================
  // divider taps: a tap ticks when all masked divider bits are one
  localparam logic [13:0] TAP_FOSC4     = 14'h0003;
  localparam logic [13:0] TAP_FOSC64    = 14'h003F;
  localparam logic [13:0] TAP_FOSC1024  = 14'h03FF;
  localparam logic [13:0] TAP_FOSC16384 = 14'h3FFF;
  localparam logic [13:0] DIV_ONE       = 14'h0001;
  localparam logic [13:0] DIV_LOW_MASK  = 14'h03FF;

  // ==========================================================
  // counter constants
  localparam logic [3:0] WDT_MAX   = 4'hF;
  localparam logic [3:0] WDT_ONE   = 4'h1;
  localparam logic [7:0] CNT_ZERO  = 8'h00;
  localparam logic [7:0] CNT_UNDER = 8'hFF;
  localparam logic [7:0] CNT_ONE   = 8'h01;

  // ==========================================================
  // event flag and enable bit positions
  localparam int EV_DIV = 0;
  localparam int EV_T0  = 1;
  localparam int EV_T1  = 7;

  // mode register bit positions
  localparam int MODE_CLK_SEL = 0;
  localparam int MODE_EXT_SRC = 1;
  localparam int MODE_TONE    = 2;
  localparam int MODE_START   = 3;

  // prescale flag bit that slows the watchdog
  localparam int PMF_WDT_SLOW = 3;

  // ==========================================================
  // whole state of the unit, registered at once
  typedef struct packed {
    logic [13:0] div;
    logic [3:0]  wdt;
    logic [3:0]  watchdog_prescale_flags;
    logic [3:0]  mode0;
    logic [3:0]  mode1;
    logic [7:0]  t0Cnt;
    logic [7:0]  t1Cnt;
    logic [7:0]  t1Buf;
    logic [7:0]  flags;
    logic [2:0]  intReq;
    logic [2:0]  holdRel;
    logic        chipRst;
    logic        toneSq;
    logic        toneOut;
    logic        pinSync1;
    logic        pinSync2;
    logic        pinPrev;
  } ttu_state_type;

endpackage

// File: ttu_timekeeping_timer_unit.sv
// timekeeping unit: divider, watchdog, one-shot and auto-reload timers
`timescale 1ns/100ps
`default_nettype none

module ttu_timekeeping_timer_unit (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // static option and command strobes from the core
  input  wire logic       watchdogOption,
  input  wire logic       divClearCmd,
  input  wire logic       wdtClearCmd,
  input  wire logic       pmfSetCmd,
  input  wire logic       pmfClrCmd,
  input  wire logic [3:0] pmfMask,
  // mode register writes
  input  wire logic       mode0WrEn,
  input  wire logic       mode1WrEn,
  input  wire logic [3:0] modeData,
  // timer loads
  input  wire logic       t0LowWr,
  input  wire logic       t0HighWr,
  input  wire logic       t0ImmWr,
  input  wire logic       t1LowWr,
  input  wire logic       t1HighWr,
  input  wire logic       t1ImmWr,
  input  wire logic [3:0] nibbleData,
  input  wire logic [7:0] immData,
  // enables held by the core and flag clears on acceptance
  input  wire logic [7:0] interrupt_enable_bits,
  input  wire logic [7:0] hold_release_enable_bits,
  input  wire logic [7:0] eventClear,
  // pins
  input  wire logic       port_c_bit0_pin,
  input  wire logic       waveformIn,
  // outputs to the core and the tone pin
  output logic      [7:0] event_flags,
  output logic      [2:0] intRequest,
  output logic      [2:0] holdRelease,
  output logic            chipResetReq,
  output logic            tone_output_pin
);

  // ==========================================================
  // state and helpers
  ttu_pkg::ttu_state_type stateReg;
  ttu_pkg::ttu_state_type stateNext;

  logic       divOvf;
  logic       wdtTick;
  logic       t0Tick;
  logic       t1Tick;
  logic       t0Under;
  logic       t1Under;
  logic       pinFall;
  logic       t0Wr;
  logic       t1Wr;
  logic [7:0] setEv;

  // tap tick: every masked divider stage is at one
  function automatic logic tapTick(input logic [13:0] d, input logic [13:0] m);
    tapTick = ((d & m) == m);
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    stateNext = stateReg;
    setEv     = '0;
    t0Wr      = t0LowWr | t0HighWr | t0ImmWr | mode0WrEn;
    t1Wr      = t1LowWr | t1HighWr | t1ImmWr | mode1WrEn;

    // divider: low stages never disturbed by the clear
    divOvf = tapTick(stateReg.div, ttu_pkg::TAP_FOSC16384);
    stateNext.div = stateReg.div + ttu_pkg::DIV_ONE;
    if (divClearCmd) begin
      stateNext.div = stateNext.div & ttu_pkg::DIV_LOW_MASK;
    end
    setEv[ttu_pkg::EV_DIV] = divOvf;

    // prescale flags: clear applied after set, so both together clears
    stateNext.watchdog_prescale_flags = (stateReg.watchdog_prescale_flags | (pmfSetCmd ? pmfMask : 4'h0))
                    & ~(pmfClrCmd ? pmfMask : 4'h0);

    // watchdog prescale taken from the divider chain
    wdtTick = stateReg.watchdog_prescale_flags[ttu_pkg::PMF_WDT_SLOW] ? divOvf
            : tapTick(stateReg.div, ttu_pkg::TAP_FOSC1024);
    stateNext.chipRst = 1'b0;
    if (wdtClearCmd) begin
      stateNext.wdt = '0;
    end else if (watchdogOption && wdtTick) begin
      stateNext.wdt = stateReg.wdt + ttu_pkg::WDT_ONE;
      stateNext.chipRst = (stateReg.wdt == ttu_pkg::WDT_MAX);
    end

    // one-shot timer; any write has priority over counting
    t0Tick = stateReg.mode0[ttu_pkg::MODE_CLK_SEL]
           ? tapTick(stateReg.div, ttu_pkg::TAP_FOSC1024)
           : tapTick(stateReg.div, ttu_pkg::TAP_FOSC4);
    t0Under = stateReg.mode0[ttu_pkg::MODE_START] && t0Tick && !t0Wr
              && (stateReg.t0Cnt == ttu_pkg::CNT_ZERO);
    if (t0LowWr) begin
      stateNext.t0Cnt[3:0] = nibbleData;
      stateNext.mode0[ttu_pkg::MODE_START] = 1'b0;
    end else if (t0HighWr) begin
      stateNext.t0Cnt[7:4] = nibbleData;
      stateNext.mode0[ttu_pkg::MODE_START] = 1'b0;
    end else if (t0ImmWr) begin
      stateNext.t0Cnt = immData;
    end else if (mode0WrEn) begin
      stateNext.mode0 = modeData & 4'h9;
    end else if (stateReg.mode0[ttu_pkg::MODE_START] && t0Tick) begin
      stateNext.t0Cnt = stateReg.t0Cnt - ttu_pkg::CNT_ONE;
      if (t0Under) begin
        stateNext.mode0[ttu_pkg::MODE_START] = 1'b0;
      end
    end
    setEv[ttu_pkg::EV_T0] = t0Under;

    // external pin: third stage gives a clean falling edge
    stateNext.pinSync1 = port_c_bit0_pin;
    stateNext.pinSync2 = stateReg.pinSync1;
    stateNext.pinPrev  = stateReg.pinSync2;
    pinFall = stateReg.pinPrev && !stateReg.pinSync2;

    // reload timer source select
    if (stateReg.mode1[ttu_pkg::MODE_EXT_SRC]) begin
      t1Tick = pinFall;
    end else if (stateReg.mode1[ttu_pkg::MODE_CLK_SEL]) begin
      t1Tick = tapTick(stateReg.div, ttu_pkg::TAP_FOSC64);
    end else begin
      t1Tick = 1'b1;
    end
    t1Under = stateReg.mode1[ttu_pkg::MODE_START] && t1Tick && !t1Wr
              && (stateReg.t1Cnt == ttu_pkg::CNT_ZERO);
    if (t1LowWr) begin
      stateNext.t1Buf[3:0] = nibbleData;
      stateNext.mode1[ttu_pkg::MODE_START] = 1'b0;
    end else if (t1HighWr) begin
      stateNext.t1Buf[7:4] = nibbleData;
      stateNext.mode1[ttu_pkg::MODE_START] = 1'b0;
    end else if (t1ImmWr) begin
      stateNext.t1Buf = immData;
      stateNext.t1Cnt = immData;
      stateNext.mode1[ttu_pkg::MODE_START] = 1'b1;
    end else if (mode1WrEn) begin
      stateNext.mode1 = modeData;
      if (modeData[ttu_pkg::MODE_START]) begin
        stateNext.t1Cnt = stateReg.t1Buf;
      end
    end else if (t1Under) begin
      stateNext.t1Cnt  = stateReg.t1Buf;
      stateNext.toneSq = !stateReg.toneSq;
    end else if (stateReg.mode1[ttu_pkg::MODE_START] && t1Tick) begin
      stateNext.t1Cnt = stateReg.t1Cnt - ttu_pkg::CNT_ONE;
    end
    setEv[ttu_pkg::EV_T1] = t1Under;

    // tone pin route
    stateNext.toneOut = stateNext.mode1[ttu_pkg::MODE_TONE]
                      ? stateNext.toneSq : waveformIn;

    // flags: clears first, events last so a set is never lost
    stateNext.flags = stateReg.flags & ~eventClear;
    if (mode0WrEn && modeData[ttu_pkg::MODE_START]) begin
      stateNext.flags[ttu_pkg::EV_T0] = 1'b0;
    end
    if ((mode1WrEn && modeData[ttu_pkg::MODE_START]) || t1ImmWr) begin
      stateNext.flags[ttu_pkg::EV_T1] = 1'b0;
    end
    stateNext.flags = stateNext.flags | setEv;

    // requests: level interrupts, one-cycle hold release
    stateNext.intReq = {stateNext.flags[ttu_pkg::EV_T1]
                          && interrupt_enable_bits[ttu_pkg::EV_T1],
                        stateNext.flags[ttu_pkg::EV_T0]
                          && interrupt_enable_bits[ttu_pkg::EV_T0],
                        stateNext.flags[ttu_pkg::EV_DIV]
                          && interrupt_enable_bits[ttu_pkg::EV_DIV]};
    stateNext.holdRel = {setEv[ttu_pkg::EV_T1] && hold_release_enable_bits[ttu_pkg::EV_T1],
                         setEv[ttu_pkg::EV_T0] && hold_release_enable_bits[ttu_pkg::EV_T0],
                         setEv[ttu_pkg::EV_DIV]
                           && hold_release_enable_bits[ttu_pkg::EV_DIV]};
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // outputs straight from the state flops
  assign event_flags     = stateReg.flags;
  assign intRequest      = stateReg.intReq;
  assign holdRelease     = stateReg.holdRel;
  assign chipResetReq    = stateReg.chipRst;
  assign tone_output_pin = stateReg.toneOut;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // first edge after reset has no valid history, so skip it
  div_advance_a: assert property ($past(rst_n) && !$past(divClearCmd)
    |-> stateReg.div == $past(stateReg.div) + ttu_pkg::DIV_ONE)
    else $error("divider did not advance");
  div_event_a: assert property ($past(stateReg.div) == ttu_pkg::TAP_FOSC16384
    |-> stateReg.flags[ttu_pkg::EV_DIV])
    else $error("divider overflow did not set flag");
  div_clear_a: assert property ($past(divClearCmd) |-> stateReg.div[13:10] == 4'h0
    && stateReg.div[9:0] == $past(stateReg.div[9:0]) + 10'h001)
    else $error("divider clear disturbed low stages");
  div_irq_a: assert property (intRequest[0] == (stateReg.flags[ttu_pkg::EV_DIV]
    && $past(interrupt_enable_bits[ttu_pkg::EV_DIV])))
    else $error("divider interrupt request wrong");
  div_hold_a: assert property (holdRelease[0] == (
    $past(stateReg.div) == ttu_pkg::TAP_FOSC16384
    && $past(hold_release_enable_bits[ttu_pkg::EV_DIV])))
    else $error("divider hold release wrong");
  wdt_disabled_a: assert property (!$past(watchdogOption) && !$past(wdtClearCmd)
    |-> stateReg.wdt == $past(stateReg.wdt) && !chipResetReq)
    else $error("disabled watchdog moved");
  wdt_clear_a: assert property (wdtClearCmd |=> stateReg.wdt == 4'h0)
    else $error("watchdog clear ignored");
  pmf_set_a: assert property (pmfSetCmd && pmfMask[3] && !pmfClrCmd
    |=> stateReg.watchdog_prescale_flags[ttu_pkg::PMF_WDT_SLOW])
    else $error("prescale flag not set");
  t0_halt_a: assert property (t0LowWr || t0HighWr
    |=> !stateReg.mode0[ttu_pkg::MODE_START])
    else $error("one-shot timer not halted by write");
  t0_start_a: assert property (mode0WrEn && modeData[ttu_pkg::MODE_START]
    && !t0LowWr && !t0HighWr && !t0ImmWr |=> stateReg.mode0[ttu_pkg::MODE_START]
    && !stateReg.flags[ttu_pkg::EV_T0])
    else $error("one-shot start did not clear its flag");
  t0_underflow_a: assert property (t0Under |=> stateReg.t0Cnt == ttu_pkg::CNT_UNDER
    && !stateReg.mode0[ttu_pkg::MODE_START] && stateReg.flags[ttu_pkg::EV_T0])
    else $error("one-shot underflow wrong");
  t0_irq_a: assert property (intRequest[1] == (stateReg.flags[ttu_pkg::EV_T0]
    && $past(interrupt_enable_bits[ttu_pkg::EV_T0])))
    else $error("one-shot interrupt request wrong");
  t0_reserved_a: assert property ((stateReg.mode0 & 4'h6) == 4'h0)
    else $error("one-shot reserved mode bits stored");
  t1_half_halt_a: assert property (t1LowWr || t1HighWr
    |=> !stateReg.mode1[ttu_pkg::MODE_START] && stateReg.t1Cnt == $past(stateReg.t1Cnt))
    else $error("reload half write did not halt");
  t1_start_a: assert property (mode1WrEn && modeData[ttu_pkg::MODE_START]
    && !t1LowWr && !t1HighWr && !t1ImmWr |=> stateReg.t1Cnt == $past(stateReg.t1Buf)
    && !stateReg.flags[ttu_pkg::EV_T1])
    else $error("reload start did not copy buffer");
  t1_reload_a: assert property (t1Under |=> stateReg.t1Cnt == $past(stateReg.t1Buf)
    && stateReg.flags[ttu_pkg::EV_T1] && stateReg.mode1[ttu_pkg::MODE_START])
    else $error("reload timer did not reload");
  t1_irq_a: assert property (intRequest[2] == (stateReg.flags[ttu_pkg::EV_T1]
    && $past(interrupt_enable_bits[ttu_pkg::EV_T1])))
    else $error("reload interrupt request wrong");
  t1_hold_a: assert property (holdRelease[2] == ($past(t1Under)
    && $past(hold_release_enable_bits[ttu_pkg::EV_T1])))
    else $error("reload hold release wrong");
  t1_imm_a: assert property (t1ImmWr |=> stateReg.t1Cnt == $past(immData)
    && stateReg.mode1[ttu_pkg::MODE_START])
    else $error("immediate reload load wrong");
  tone_toggle_a: assert property (t1Under
    |=> stateReg.toneSq != $past(stateReg.toneSq))
    else $error("tone did not toggle");
  flag_keep_a: assert property ($past(stateReg.flags[ttu_pkg::EV_DIV])
    && !$past(eventClear[ttu_pkg::EV_DIV]) |-> stateReg.flags[ttu_pkg::EV_DIV])
    else $error("divider flag lost");

  t0_under_c: cover property (t0Under);
  t1_ext_c: cover property (stateReg.mode1[ttu_pkg::MODE_EXT_SRC] && t1Under);
  wdt_reset_c: cover property (chipResetReq);
  hold_rel_c: cover property (holdRelease[2]);

endmodule

`default_nettype wire

// File: ttu_core_model.sv
// core-side model: accepts interrupts and services the watchdog
`timescale 1ns/100ps
`default_nettype none

module ttu_core_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // requests and behaviour controls
  input  wire logic [2:0] intRequest,
  input  wire logic       acceptEn,
  input  wire logic       keepAlive,
  // commands back to the unit
  output logic      [7:0] eventClear,
  output logic            wdtClearCmd
);
  int tick;

  // ==========================================================
  // acceptance and housekeeping
  // updates just after the rising edge; bench controls settle at the falling edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eventClear  <= 8'h00;
      wdtClearCmd <= 1'b0;
      tick        <= 0;
    end else begin
      eventClear  <= acceptEn ? {intRequest[2], 5'h00, intRequest[1:0]} : 8'h00;
      tick        <= (tick == 999) ? 0 : tick + 1;
      // cleared every 1000 cycles, inside one 1024-cycle tick, so a kept-alive count never passes one
      wdtClearCmd <= keepAlive && tick == 0;
    end
  end
endmodule
`default_nettype wire

// File: ttu_timekeeping_timer_unit_bench.sv
// self-checking bench of the timekeeping timer unit
`timescale 1ns/100ps
`default_nettype none

module ttu_timekeeping_timer_unit_bench;
  // ==========================================================
  // stimulus and observation
  logic       core_clk = 0, rst_n = 0, watchdogOption = 0, divClearCmd = 0;
  logic       pmfSetCmd = 0, pmfClrCmd = 0, mode0WrEn = 0, mode1WrEn = 0;
  logic       t0LowWr = 0, t0HighWr = 0, t0ImmWr = 0, t1LowWr = 0, t1HighWr = 0;
  logic       t1ImmWr = 0, port_c_bit0_pin = 1, waveformIn = 0, acceptEn = 0;
  logic       keepAlive = 0, wdtClearCmd, chipResetReq, tone_output_pin, prev;
  logic [3:0] pmfMask = 4'h8, modeData = 4'h0, nibbleData = 4'h0;
  logic [7:0] immData = 8'h00, eventClear, event_flags, sel;
  logic [7:0] interrupt_enable_bits = 8'h83, hold_release_enable_bits = 8'h83;
  logic [2:0] intRequest, holdRelease;
  int         errCount = 0, compares = 0, n;

  always #10 core_clk = ~core_clk;

  ttu_timekeeping_timer_unit i_dut (.core_clk, .rst_n, .watchdogOption, .divClearCmd,
    .wdtClearCmd, .pmfSetCmd, .pmfClrCmd, .pmfMask, .mode0WrEn, .mode1WrEn, .modeData,
    .t0LowWr, .t0HighWr, .t0ImmWr, .t1LowWr, .t1HighWr, .t1ImmWr, .nibbleData, .immData,
    .interrupt_enable_bits, .hold_release_enable_bits, .eventClear, .port_c_bit0_pin,
    .waveformIn, .event_flags, .intRequest, .holdRelease, .chipResetReq, .tone_output_pin);

  ttu_core_model i_core (.core_clk, .rst_n, .intRequest, .acceptEn, .keepAlive,
    .eventClear, .wdtClearCmd);

  // ==========================================================
  // shared helpers
  task automatic endSim();
    $display("errors %0d compares %0d", errCount, compares);
    if (errCount == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one-cycle command pulse; data is set by the caller beforehand
  task automatic strobe(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  // index 0..7 watches a flag, 8 watches the chip reset request
  task automatic waitFor(input int idx, input int lim, input bit must);
    n = 0;
    sel = (idx == 8) ? {7'h00, chipResetReq} : event_flags >> idx;
    while (sel[0] !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
      sel = (idx == 8) ? {7'h00, chipResetReq} : event_flags >> idx;
    end
    if (must && n >= lim) begin
      errCount++;
      $display("BAD %0t: wait ran out", $time);
      endSim();
    end
  endtask

  task automatic toggles(input int cyc);
    n = 0;
    prev = tone_output_pin;
    repeat (cyc) begin
      @(negedge core_clk);
      if (tone_output_pin !== prev) n++;
      prev = tone_output_pin;
    end
  endtask

  task automatic clearAll();
    acceptEn = 1'b1;
    repeat (4) @(negedge core_clk);
    acceptEn = 1'b0;
  endtask

  task automatic fall();
    port_c_bit0_pin = 1'b0;
    repeat (4) @(negedge core_clk);
    port_c_bit0_pin = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic testDivider();
    chk(event_flags, 8'h00);
    // let the top stages fill so the clear has something to remove
    repeat (1100) @(negedge core_clk);
    strobe(divClearCmd);
    waitFor(0, 17000, 1);
    chk(8'(n > 16300 && n < 16310), 8'h01);
    chk({5'h00, holdRelease}, 8'h01);
    repeat (50) @(negedge core_clk);
    chk({5'h00, intRequest}, 8'h01);
    chk({5'h00, holdRelease}, 8'h00);
    chk(event_flags, 8'h01);
    clearAll();
    chk(event_flags, 8'h00);
  endtask

  task automatic testOneShot();
    immData = 8'h03;
    strobe(t0ImmWr);
    modeData = 4'h8;
    strobe(mode0WrEn);
    waitFor(1, 40, 1);
    chk(8'(n > 9 && n < 19), 8'h01);
    chk({5'h00, holdRelease}, 8'h02);
    repeat (2) @(negedge core_clk);
    chk({5'h00, intRequest}, 8'h02);
    strobe(mode0WrEn);
    chk(event_flags, 8'h00);
    strobe(t0LowWr);
    repeat (1200) @(negedge core_clk);
    chk(event_flags, 8'h00);
    // reload by halves, then run slow with both enables off
    nibbleData = 4'h1;
    strobe(t0LowWr);
    nibbleData = 4'h0;
    strobe(t0HighWr);
    interrupt_enable_bits = 8'h81;
    hold_release_enable_bits = 8'h81;
    modeData = 4'h9;
    strobe(mode0WrEn);
    waitFor(1, 2200, 1);
    chk(8'(n > 1020), 8'h01);
    chk({5'h00, intRequest}, 8'h00);
    chk({5'h00, holdRelease}, 8'h00);
    interrupt_enable_bits = 8'h83;
    hold_release_enable_bits = 8'h83;
    clearAll();
  endtask

  task automatic testReload();
    modeData = 4'h4;
    strobe(mode1WrEn);
    immData = 8'h01;
    strobe(t1ImmWr);
    toggles(40);
    chk(8'(n), 8'h14);
    chk(event_flags, 8'h80);
    chk({5'h00, intRequest}, 8'h04);
    strobe(t1LowWr);
    toggles(20);
    chk(8'(n), 8'h00);
    modeData = 4'h0;
    strobe(mode1WrEn);
    waveformIn = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({7'h00, tone_output_pin}, 8'h01);
    waveformIn = 1'b0;
    clearAll();
    modeData = 4'h9;
    strobe(mode1WrEn);
    waitFor(7, 80, 1);
    clearAll();
    waitFor(7, 80, 1);
    chk(8'(n > 54 && n < 64), 8'h01);
    nibbleData = 4'h2;
    strobe(t1LowWr);
    modeData = 4'hA;
    strobe(mode1WrEn);
    chk(event_flags, 8'h00);
    fall();
    fall();
    chk(event_flags, 8'h00);
    fall();
    chk(event_flags, 8'h80);
    clearAll();
  endtask

  task automatic testWatchdog();
    watchdogOption = 1'b1;
    keepAlive = 1'b1;
    waitFor(8, 20000, 0);
    chk(8'(n == 20000), 8'h01);
    keepAlive = 1'b0;
    strobe(pmfSetCmd);
    waitFor(8, 20000, 0);
    chk(8'(n == 20000), 8'h01);
    strobe(pmfClrCmd);
    waitFor(8, 17500, 1);
    chk(8'(n > 13000), 8'h01);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    testDivider();
    testOneShot();
    testReload();
    testWatchdog();
    endSim();
  end
endmodule
`default_nettype wire
